// >>> inc/beam_eval_map.svh
// Register offsets, field positions, reset values and counts of the beam evaluation block
`ifndef BEAM_EVAL_MAP_SVH
`define BEAM_EVAL_MAP_SVH
`define BEAMS 32
`define CNT_W 6
`define FUNC_W 4
`define ADR_CTRL 8'h00
`define ADR_OPT 8'h04
`define ADR_HOLD_EN 8'h08
`define ADR_STATUS 8'h0c
`define ADR_COUNT 8'h10
`define ADR_EVAL_VEC 8'h14
`define ADR_LIVE_VEC 8'h18
`define ADR_BLANK_MASK 8'h1c
`define ADR_TEACH_MASK 8'h20
`define ADR_CMD 8'h24
`define CTRL_MODE_LSB 0
`define CTRL_OPMODE_LSB 2
`define CTRL_PERSIST_BIT 4
`define CTRL_BUS_TRIG_BIT 5
`define CTRL_IN_TRIG_BIT 6
`define CTRL_IN_TEACH_BIT 7
`define CTRL_XMODE_LSB 8
`define OPT_RESP_BIT 0
`define OPT_RES_LSB 1
`define OPT_ABSORB_LSB 3
`define OPT_HSS_OFF_BIT 5
`define OPT_SPACING_LSB 8
`define OPT_PHYS_LSB 16
`define OPT_MINOBJ_LSB 24
`define CMD_BLANK_BIT 0
`define SPACING_MIN 8'h0a
`define PHYS_MAX 9'h0ff
`define CTRL_RESET 32'h0000_0000
`define OPT_RESET 32'h00_20_0a_02
`define HOLD_EN_RESET 4'hf
`endif

// >>> inc/beam_eval_pkg.sv
// Types of the beam evaluation block
package beam_eval_pkg;
   typedef enum logic [1:0] {standard_mode, blocked_hold_mode, lost_hold_mode} eval_mode_type;
   typedef enum logic [1:0] {op_standard, op_dust, op_transparent} op_mode_type;
   typedef enum logic [1:0] {resv_high, resv_medium, resv_low} reserve_type;
   typedef enum logic [1:0] {absorb_10, absorb_15, absorb_30} min_absorption_type;
   typedef enum logic [1:0] {x_auto, x_switching, x_measuring} cross_sel_type;
endpackage

// >>> design/beam_evaluation_hold.sv
// Beam status evaluation with blanking, performance options, cross beam and hold modes
`timescale 1ns/10ps
`include "beam_eval_map.svh"
module beam_evaluation_hold (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_ce,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Beam scan
   input wire logic [`BEAMS-1:0] i_beam_blocked,
   input wire logic i_scan_valid,
   input wire logic [`BEAMS-1:0] i_diag_blocked,
   // Digital input pin
   input wire logic i_dig_in,
   // Results
   output logic o_object_detected,
   output logic [`CNT_W-1:0] o_blocked_count,
   output logic [`CNT_W-1:0] o_first_blocked,
   output logic [`CNT_W-1:0] o_last_blocked,
   output logic o_high_speed_scan,
   output logic o_parallel_beam,
   output logic o_hold_trigger_flag,
   output logic o_teach_start
);
   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [`CNT_W-1:0] count_ones(input logic [`BEAMS-1:0] v);
      logic [`CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < `BEAMS; i++) begin
         n = n + {{(`CNT_W-1){1'b0}}, v[i]};
      end
      return n;
   endfunction

   function automatic logic [`CNT_W-1:0] first_one(input logic [`BEAMS-1:0] v);
      logic [`CNT_W-1:0] n;
      n = '0;
      for (int i = `BEAMS-1; i >= 0; i--) begin
         if (v[i]) begin
            n = `CNT_W'(i + 1);
         end
      end
      return n;
   endfunction

   function automatic logic [`CNT_W-1:0] last_one(input logic [`BEAMS-1:0] v);
      logic [`CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < `BEAMS; i++) begin
         if (v[i]) begin
            n = `CNT_W'(i + 1);
         end
      end
      return n;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic pin_meta_r;
   logic pin_sync_r;
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
      end else if (i_ce) begin
         pin_meta_r <= i_dig_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl_r;
   logic [31:0] opt_r;
   logic [`FUNC_W-1:0] hold_en_r;
   logic [`BEAMS-1:0] blank_mask_r;
   logic [`BEAMS-1:0] teach_mask_r;
   logic [31:0] ctrl_nxt;
   logic [31:0] opt_nxt;
   logic ack_r;
   logic wr;
   beam_eval_pkg::eval_mode_type mode;
   beam_eval_pkg::op_mode_type opmode;
   assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
   assign mode = beam_eval_pkg::eval_mode_type'(ctrl_r[`CTRL_MODE_LSB +: 2]);
   assign opmode = beam_eval_pkg::op_mode_type'(ctrl_r[`CTRL_OPMODE_LSB +: 2]);

   // ****************************************
   // Write legality
   // ****************************************
   // Refused resolution and absorption fields keep their old value and a refused fast response is forced to 1, so software never sees half an option
   always_comb begin
      logic [31:0] m;
      m = merge(opt_r, i_wb_dat, i_wb_sel);
      opt_nxt = m;
      if (!m[`OPT_RESP_BIT]
          && (m[`OPT_HSS_OFF_BIT] || opmode == beam_eval_pkg::op_transparent)) begin
         opt_nxt[`OPT_RESP_BIT] = 1'b1;
      end
      if (opmode == beam_eval_pkg::op_transparent || m[`OPT_RES_LSB +: 2] == 2'h3) begin
         opt_nxt[`OPT_RES_LSB +: 2] = opt_r[`OPT_RES_LSB +: 2];
      end
      if (m[`OPT_ABSORB_LSB +: 2] == 2'h3) begin
         opt_nxt[`OPT_ABSORB_LSB +: 2] = opt_r[`OPT_ABSORB_LSB +: 2];
      end
   end
   always_comb begin
      ctrl_nxt = merge(ctrl_r, i_wb_dat, i_wb_sel);
      if (ctrl_nxt[`CTRL_MODE_LSB +: 2] == 2'h3) begin
         ctrl_nxt[`CTRL_MODE_LSB +: 2] = ctrl_r[`CTRL_MODE_LSB +: 2];
      end
      if (ctrl_nxt[`CTRL_OPMODE_LSB +: 2] == 2'h3) begin
         ctrl_nxt[`CTRL_OPMODE_LSB +: 2] = ctrl_r[`CTRL_OPMODE_LSB +: 2];
      end
      if (ctrl_nxt[`CTRL_IN_TRIG_BIT] && ctrl_nxt[`CTRL_IN_TEACH_BIT]) begin
         ctrl_nxt[`CTRL_IN_TEACH_BIT] = 1'b0;
      end
      if (ctrl_nxt[`CTRL_XMODE_LSB +: 2] == 2'h3) begin
         ctrl_nxt[`CTRL_XMODE_LSB +: 2] = ctrl_r[`CTRL_XMODE_LSB +: 2];
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ctrl_r <= `CTRL_RESET;
         opt_r <= `OPT_RESET;
         hold_en_r <= `HOLD_EN_RESET;
      end else if (i_ce && wr) begin
         unique case (i_wb_adr)
            `ADR_CTRL: ctrl_r <= ctrl_nxt;
            `ADR_OPT: opt_r <= opt_nxt;
            `ADR_HOLD_EN: hold_en_r <= i_wb_sel[0] ? i_wb_dat[`FUNC_W-1:0] : hold_en_r;
            default: ;
         endcase
      end
   end
   // Blanking: the current made beams are excluded on command
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         blank_mask_r <= '0;
         teach_mask_r <= '0;
      end else if (i_ce && wr && i_wb_adr == `ADR_CMD && i_wb_sel[0]
                   && i_wb_dat[`CMD_BLANK_BIT]) begin
         blank_mask_r <= blank_mask_r | ~i_beam_blocked;
         teach_mask_r <= ctrl_r[`CTRL_PERSIST_BIT] ? (blank_mask_r | ~i_beam_blocked)
            : '0;
      end
   end

   // ****************************************
   // Performance and cross beam
   // ****************************************
   logic cross_allowed;
   logic measure_allowed;
   logic cross_switch;
   logic cross_measure;
   beam_eval_pkg::cross_sel_type xsel;
   assign xsel = beam_eval_pkg::cross_sel_type'(ctrl_r[`CTRL_XMODE_LSB +: 2]);
   // A fast choice stored before entering transparent mode is not honoured there
   assign o_high_speed_scan = !opt_r[`OPT_RESP_BIT] && !opt_r[`OPT_HSS_OFF_BIT]
                              && opmode != beam_eval_pkg::op_transparent;
   assign o_parallel_beam = 1'b1;
   assign cross_allowed = opt_r[`OPT_SPACING_LSB +: 8] >= `SPACING_MIN
                          && opmode != beam_eval_pkg::op_transparent
                          && !o_high_speed_scan;
   assign measure_allowed = cross_allowed
                            && {1'b0, opt_r[`OPT_PHYS_LSB +: 8]} <= `PHYS_MAX;
   // Auto picks switching when the wanted object is smaller than the spacing
   assign cross_switch = cross_allowed && (xsel == beam_eval_pkg::x_switching
      || (xsel == beam_eval_pkg::x_auto
          && opt_r[`OPT_MINOBJ_LSB +: 8] < opt_r[`OPT_SPACING_LSB +: 8]));
   assign cross_measure = measure_allowed && xsel == beam_eval_pkg::x_measuring;

   // ****************************************
   // Hold evaluation
   // ****************************************
   logic [`BEAMS-1:0] live;
   logic [`BEAMS-1:0] held_r;
   logic [`BEAMS-1:0] lost_r;
   logic [1:0] mode_seen_r;
   logic armed;
   logic mode_change;
   // Diagonal paths never enter this vector; they only flag detection
   assign live = i_beam_blocked & ~blank_mask_r;
   assign armed = mode == beam_eval_pkg::blocked_hold_mode
                  && (ctrl_r[`CTRL_BUS_TRIG_BIT]
                      || (ctrl_r[`CTRL_IN_TRIG_BIT] && pin_sync_r));
   assign mode_change = mode_seen_r != ctrl_r[`CTRL_MODE_LSB +: 2];
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         mode_seen_r <= '0;
      end else if (i_ce) begin
         mode_seen_r <= ctrl_r[`CTRL_MODE_LSB +: 2];
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst || (i_ce && (mode_change || !armed))) begin
         held_r <= '0;
      end else if (i_ce && i_scan_valid) begin
         held_r <= held_r | live;
      end
   end
   // A new blocked set replaces the stored one; empty scans keep it
   always_ff @(posedge i_clock) begin
      if (i_srst || (i_ce && mode_change)) begin
         lost_r <= '0;
      end else if (i_ce && i_scan_valid && |live) begin
         lost_r <= live;
      end
   end

   // ****************************************
   // Beam functions
   // ****************************************
   logic [`BEAMS-1:0] vec_f [`FUNC_W];
   always_comb begin
      for (int f = 0; f < `FUNC_W; f++) begin
         unique case (mode)
            beam_eval_pkg::lost_hold_mode: vec_f[f] = (|live) ? live : lost_r;
            beam_eval_pkg::blocked_hold_mode:
               vec_f[f] = hold_en_r[f] ? (held_r | live) : live;
            default: vec_f[f] = live;
         endcase
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_object_detected <= 1'b0;
         o_blocked_count <= '0;
         o_first_blocked <= '0;
         o_last_blocked <= '0;
      end else if (i_ce && i_scan_valid) begin
         o_object_detected <= |vec_f[3] || (cross_switch && |i_diag_blocked);
         o_blocked_count <= count_ones(vec_f[0]);
         o_first_blocked <= first_one(vec_f[1]);
         o_last_blocked <= last_one(vec_f[2]);
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_hold_trigger_flag <= 1'b0;
         o_teach_start <= 1'b0;
      end else if (i_ce) begin
         o_hold_trigger_flag <= armed && ctrl_r[`CTRL_IN_TRIG_BIT] && pin_sync_r;
         o_teach_start <= ctrl_r[`CTRL_IN_TEACH_BIT] && pin_sync_r;
      end
   end

   // ****************************************
   // Bus read and acknowledge
   // ****************************************
   // Beam numbers are never remapped here when measuring is chosen
   // Measuring adds one virtual beam between each neighbouring real pair
   logic [7:0] beam_total;
   logic [31:0] status;
   assign beam_total = cross_measure ? 8'(2 * `BEAMS - 1) : 8'(`BEAMS);
   always_comb begin
      status = '0;
      status[0] = o_high_speed_scan;
      status[1] = armed;
      status[2] = o_hold_trigger_flag;
      status[3] = cross_allowed;
      status[4] = measure_allowed;
      status[5] = cross_switch;
      status[6] = cross_measure;
      status[15:8] = beam_total;
   end
   // The acknowledge lasts one cycle so a held request is taken only once
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ack_r <= 1'b0;
      end else if (i_ce) begin
         ack_r <= i_wb_cyc && i_wb_stb && !ack_r;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_wb_dat <= '0;
      end else if (i_ce) begin
         unique case (i_wb_adr)
            `ADR_CTRL: o_wb_dat <= ctrl_r;
            `ADR_OPT: o_wb_dat <= opt_r;
            `ADR_HOLD_EN: o_wb_dat <= {28'h0, hold_en_r};
            `ADR_STATUS: o_wb_dat <= status;
            `ADR_COUNT: o_wb_dat <= {26'h0, o_blocked_count};
            `ADR_EVAL_VEC: o_wb_dat <= vec_f[0];
            `ADR_LIVE_VEC: o_wb_dat <= live;
            `ADR_BLANK_MASK: o_wb_dat <= blank_mask_r;
            `ADR_TEACH_MASK: o_wb_dat <= teach_mask_r;
            default: o_wb_dat <= '0;
         endcase
      end
   end
   assign o_wb_ack = ack_r;
endmodule

// >>> test/beam_evaluation_hold_monitor.sv
// Port checker of the beam evaluation block, bound into its top module
`timescale 1ns/10ps
`include "beam_eval_map.svh"
module beam_evaluation_hold_monitor (
   // Clock, reset and requests
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_dig_in,
   // Watched outputs
   input wire logic o_wb_ack,
   input wire logic [`CNT_W-1:0] o_blocked_count,
   input wire logic [`CNT_W-1:0] o_first_blocked,
   input wire logic [`CNT_W-1:0] o_last_blocked,
   input wire logic o_high_speed_scan,
   input wire logic o_parallel_beam,
   input wire logic o_hold_trigger_flag,
   input wire logic o_teach_start
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack)
      else $error("no ack after request");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_parallel_kept: assert property (o_parallel_beam)
      else $error("parallel beam function off");
   a_count_range: assert property (o_blocked_count <= 6'h20)
      else $error("blocked count above beam count");
   a_first_last: assert property (o_first_blocked != 6'h00 && o_last_blocked != 6'h00
      |-> o_first_blocked <= o_last_blocked)
      else $error("first blocked beyond last blocked");
   a_scan_by_write: assert property ($changed(o_high_speed_scan) |-> o_wb_ack)
      else $error("scan setting changed without write");
   a_flag_from_pin: assert property ($rose(o_hold_trigger_flag) |->
      $past(i_dig_in, 2) || $past(i_dig_in, 3) || $past(i_dig_in, 4))
      else $error("hold flag without input");
   a_teach_from_pin: assert property (o_teach_start |->
      $past(i_dig_in, 1) || $past(i_dig_in, 2) || $past(i_dig_in, 3))
      else $error("teach start without input");
   a_one_function: assert property (!(o_teach_start && o_hold_trigger_flag))
      else $error("input drives two functions");
   c_flag: cover property (o_hold_trigger_flag);
   c_teach: cover property (o_teach_start);
   c_fast: cover property ($rose(o_high_speed_scan));
endmodule
bind beam_evaluation_hold beam_evaluation_hold_monitor mon (.i_clock(i_clock), .i_srst(i_srst),
   .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_dig_in(i_dig_in),
   .o_wb_ack(o_wb_ack), .o_blocked_count(o_blocked_count), .o_first_blocked(o_first_blocked),
   .o_last_blocked(o_last_blocked), .o_high_speed_scan(o_high_speed_scan),
   .o_parallel_beam(o_parallel_beam), .o_hold_trigger_flag(o_hold_trigger_flag),
   .o_teach_start(o_teach_start));

// >>> test/trigger_pin_model.sv
// Model of the field control driving the hardware trigger pin
`timescale 1ns/10ps
module trigger_pin_model (
   // Clock and requested level
   input wire logic i_clock,
   input wire logic i_level,
   // Pin towards the block
   output logic o_dig_in = 1'b0
);
   // Level moves only after an edge; the block must synchronise it itself
   always @(posedge i_clock) o_dig_in <= i_level;
endmodule

// >>> test/tb_beam_evaluation_hold.sv
// Self-checking testbench of the beam evaluation block
`timescale 1ns/10ps
`include "beam_eval_map.svh"
module tb_beam_evaluation_hold;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, scan_v = 1'b0, pin_req = 1'b0, dig_in;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, beams = 32'h0, rd, o_wb_dat;
   logic ce = 1'b1;
   logic [31:0] diag = 32'h0;
   logic o_wb_ack, o_obj, o_hss, o_par, o_flag, o_teach;
   logic [`CNT_W-1:0] o_cnt, o_first, o_last;
   int bad_count = 0, comparisons = 0, ticks = 0;
   always #12.5 i_clock = ~i_clock;
   trigger_pin_model pin (.i_clock(i_clock), .i_level(pin_req), .o_dig_in(dig_in));
   beam_evaluation_hold dut (.i_clock(i_clock), .i_srst(i_srst), .i_ce(ce),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
      .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_beam_blocked(beams),
      .i_scan_valid(scan_v), .i_diag_blocked(diag), .i_dig_in(dig_in),
      .o_object_detected(o_obj), .o_blocked_count(o_cnt), .o_first_blocked(o_first),
      .o_last_blocked(o_last), .o_high_speed_scan(o_hss), .o_parallel_beam(o_par),
      .o_hold_trigger_flag(o_flag), .o_teach_start(o_teach));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Classic cycle: request held until ack is sampled, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_clock); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic scan(input logic [31:0] v);
      @(posedge i_clock);
      beams <= v;
      scan_v <= 1'b1;
      @(posedge i_clock);
      scan_v <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic set_pin(input logic v);
      @(posedge i_clock);
      pin_req <= v;
      repeat (6) @(posedge i_clock);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_options();
      wb(1'b0, `ADR_OPT, 32'h0);
      chk(rd, `OPT_RESET);
      wb(1'b1, `ADR_OPT, 32'h00200a00);
      chk(o_hss, 1'b1);
      chk(o_par, 1'b1);
      wb(1'b1, `ADR_CTRL, 32'h00000008);
      chk(o_hss, 1'b0);
      wb(1'b1, `ADR_OPT, 32'h00200a04);
      wb(1'b0, `ADR_OPT, 32'h0);
      chk(rd, 32'h00200a01);
      chk(o_hss, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `ADR_OPT, 32'h00200a01 | (i << 3));
         wb(1'b0, `ADR_OPT, 32'h0);
         chk(rd[4:3], (i == 3) ? 2'h2 : 2'(i));
      end
      wb(1'b1, `ADR_CTRL, 32'h00000000);
      wb(1'b1, `ADR_OPT, 32'h00200a24);
      wb(1'b0, `ADR_OPT, 32'h0);
      chk(rd, 32'h00200a25);
      chk(o_hss, 1'b0);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd[4:3], 2'h3);
      wb(1'b1, `ADR_OPT, 32'h00200925);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd[3], 1'b0);
      wb(1'b0, 8'hfc, 32'h0);
      chk(rd, 32'h0);
   endtask
   // Auto picks crossing only for objects smaller than the spacing
   task automatic t_cross();
      wb(1'b1, `ADR_OPT, 32'h05200a25);
      diag <= 32'h4;
      scan(32'h0);
      chk(o_obj, 1'b1);
      chk(o_cnt, 6'h00);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd, 32'h2038);
      wb(1'b1, `ADR_CTRL, 32'h00000200);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd, 32'h3f58);
      wb(1'b1, `ADR_OPT, 32'h0f200a25);
      wb(1'b1, `ADR_CTRL, 32'h00000100);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd, 32'h2038);
      wb(1'b1, `ADR_CTRL, 32'h00000000);
      scan(32'h0);
      chk(o_obj, 1'b0);
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk(rd, 32'h2018);
      diag <= 32'h0;
   endtask
   task automatic t_count();
      scan(32'h00000f10);
      chk(o_cnt, 6'h05);
      chk(o_first, 6'h05);
      chk(o_last, 6'h0c);
      ce <= 1'b0;
      scan(32'h3);
      chk(o_cnt, 6'h05);
      ce <= 1'b1;
   endtask
   // Hold only on the count; first blocked stays live
   task automatic t_bus_hold();
      wb(1'b1, `ADR_HOLD_EN, 32'h1);
      wb(1'b1, `ADR_CTRL, 32'h00000021);
      scan(32'h1);
      scan(32'h2);
      chk(o_cnt, 6'h02);
      chk(o_first, 6'h02);
      wb(1'b1, `ADR_CTRL, 32'h00000001);
      scan(32'h0);
      chk(o_cnt, 6'h00);
   endtask
   task automatic t_pin_hold();
      wb(1'b1, `ADR_CTRL, 32'h00000080);
      set_pin(1'b1);
      chk(o_teach, 1'b1);
      wb(1'b1, `ADR_CTRL, 32'h000000c1);
      repeat (3) @(posedge i_clock);
      chk(o_teach, 1'b0);
      chk(o_flag, 1'b1);
      scan(32'h4);
      scan(32'h8);
      chk(o_cnt, 6'h02);
      set_pin(1'b0);
      scan(32'h0);
      chk(o_cnt, 6'h00);
      chk(o_flag, 1'b0);
   endtask
   task automatic t_lost();
      wb(1'b1, `ADR_CTRL, 32'h00000002);
      scan(32'h10);
      scan(32'h0);
      chk(o_last, 6'h05);
      chk(o_cnt, 6'h01);
      scan(32'h100);
      chk(o_last, 6'h09);
      chk(o_first, 6'h09);
      wb(1'b1, `ADR_CTRL, 32'h00000003);
      wb(1'b0, `ADR_CTRL, 32'h0);
      chk(rd[1:0], 2'h2);
      wb(1'b1, `ADR_CTRL, 32'h00000000);
      wb(1'b1, `ADR_CTRL, 32'h00000002);
      scan(32'h0);
      chk(o_cnt, 6'h00);
   endtask
   task automatic t_blank();
      wb(1'b1, `ADR_CTRL, 32'h00000010);
      scan(32'hffffff00);
      wb(1'b1, `ADR_CMD, 32'h1);
      scan(32'hffffffff);
      chk(o_cnt, 6'h18);
      chk(o_first, 6'h09);
      wb(1'b0, `ADR_BLANK_MASK, 32'h0);
      chk(rd, 32'h000000ff);
      wb(1'b0, `ADR_TEACH_MASK, 32'h0);
      chk(rd, 32'h000000ff);
   endtask
   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge i_clock) begin
      ticks <= ticks + 1;
      if (ticks == 4000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      repeat (2) @(posedge i_clock);
      i_srst <= 1'b0;
      t_options();
      t_cross();
      t_count();
      t_bus_hold();
      t_pin_hold();
      t_lost();
      t_blank();
      results();
   end
endmodule
